/* File: dsq_pkg.sv */
/*
 Constants for the dual-slope converter sequencer and display scan block.
 Assumes a 40 MHz system clock and a 2.41152 MHz master clock.
*/
`default_nettype none
package dsq_pkg;
   // ****************************************
   // Clock rates and timebase
   // ****************************************
   localparam longint CLK_HZ = 40000000;
   localparam longint MCLK_HZ = 2411520;
   localparam int ACC_W = 26;
   localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(MCLK_HZ);
   localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);
   localparam int PRESCALE = 6;
   localparam logic [2:0] PRE_LAST = 3'(PRESCALE - 1);
   localparam int CNT_W = 8;
   localparam longint MCLK_PER_WRAP = PRESCALE * 256;
   // ****************************************
   // Result counter and phases
   // ****************************************
   localparam logic [7:0] SOFT_LAST = 8'h9C;
   localparam int SENSE_US = 1910;
   localparam longint SENSE_WRAPS = (SENSE_US * MCLK_HZ) / (MCLK_PER_WRAP * 1000000);
   localparam logic [7:0] SENSE_START = SOFT_LAST - 8'(SENSE_WRAPS);
   localparam logic [3:0] CFG_MAX = 4'hD;
   localparam logic [3:0] CFG_FINAL_LAST = 4'hC;
   localparam logic [1:0] GAIN_X20 = 2'h0;
   localparam logic [1:0] SRC_RJ = 2'h2;
   typedef enum logic [2:0] {
      DSQ_IDLE, DSQ_AUTO_ZERO, DSQ_INT_IN, DSQ_SIGN_SENSE, DSQ_INT_REF
   } dsq_phase_e;
   // ****************************************
   // Update cycle and display
   // ****************************************
   localparam longint PRELIM_MS = 200;
   localparam longint FINAL_MS = 300;
   localparam longint FLASH_MS = 400;
   localparam logic [9:0] PRELIM_WRAPS = 10'((PRELIM_MS * MCLK_HZ) / (MCLK_PER_WRAP * 1000));
   localparam logic [9:0] FINAL_WRAPS = 10'((FINAL_MS * MCLK_HZ) / (MCLK_PER_WRAP * 1000));
   localparam logic [9:0] FLASH_WRAPS = 10'((FLASH_MS * MCLK_HZ) / (MCLK_PER_WRAP * 1000));
   localparam logic [3:0] SCAN_LAST = 4'h8;
   localparam logic [3:0] DIGITS = 4'h7;
   localparam logic ROM_SPACE = 1'b0;
endpackage
`default_nettype wire

/* File: dsq_ctrl.sv */
/*
 Converter sequencer, timebase, result latch, flag inputs, address latch
 and display latches. Assumes all inputs are synchronous to clk_i and that
 processor pulses last one clock.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Master clock divided by six clocks a free-running 8-bit counter.
// - Every counter wrap raises the processor interrupt, period about 636.9 us.
// - Result is hardware counter extended by a software count up to 156.
// - Input integration lasts one full result-counter pass, 100 ms.
// - Conversion runs auto-zero, input integration, polarity sensing, reference integration.
// - Conversion-done pulse captures the 8-bit counter into a readable latch.
// - Configure and phase-step together make a reset starting auto-zero.
// - Up to 12 configure pulses after reset set up the conversion; the count stops at 13.
// - Each phase-step pulse moves the converter to its next phase, except in idle where it is ignored.
// - Configure count encodes gain, preliminary or final, and input source.
// - Reference-junction conversions always use gain 20.
// - Four flags: low battery, polarity pulse, unit switch, range sense.
// - A 5-bit latch supplies the top bits of the 13-bit address.
// - Two bus-loaded 8-bit latches hold digit select and segment pattern.
// - Nine-interval scan of seven digits; two intervals leave all dark.
// - Unit switch high means Fahrenheit, low means Celsius.
// - Range flag is the digit drive selected by the range switch.
// - Low battery makes the display flash on and off.
// - A zero reference-junction reading marks self-check; no correction.
// - Otherwise junction correction is applied to the measured voltage.
// - Each update: 200 ms preliminary then 300 ms final conversion.
module dsq_ctrl (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic configure_pulse_i,
   input wire logic phase_step_pulse_i,
   input wire logic polarity_done_line_i,
   input wire logic low_battery_i,
   input wire logic unit_switch_i,
   input wire logic [7:0] range_position_i,
   input wire logic [7:0] bus_data_i,
   input wire logic digit_wr_i,
   input wire logic segment_wr_i,
   input wire logic addr_hi_wr_i,
   input wire logic [7:0] addr_lo_i,
   input wire logic mem_req_i,
   output logic irq_o,
   output logic [7:0] counter_o,
   output logic [7:0] result_latch_o,
   output logic [7:0] soft_count_o,
   output logic conv_done_o,
   output logic [2:0] phase_o,
   output logic az_reset_o,
   output logic [3:0] cfg_count_o,
   output logic [1:0] gain_sel_o,
   output logic [1:0] input_sel_o,
   output logic final_conv_o,
   output logic self_check_o,
   output logic junction_corr_o,
   output logic final_window_o,
   output logic update_tick_o,
   output logic low_battery_flag_input_o,
   output logic polarity_flag_input_o,
   output logic unit_switch_flag_input_o,
   output logic range_sense_flag_input_o,
   output logic [7:0] digit_select_latch_o,
   output logic [7:0] segment_pattern_latch_o,
   output logic [3:0] scan_slot_o,
   output logic [12:0] mem_addr_o,
   output logic rom_sel_o,
   output logic ram_sel_o
);
   // ****************************************
   // Timebase
   // ****************************************
   logic [dsq_pkg::ACC_W-1:0] acc_q;
   logic [2:0] pre_q;
   logic [7:0] cnt_q;
   wire [dsq_pkg::ACC_W-1:0] acc_sum = acc_q + dsq_pkg::ACC_STEP;
   wire mclk_tick = acc_sum >= dsq_pkg::ACC_WRAP;
   wire cnt_step = mclk_tick && (pre_q == dsq_pkg::PRE_LAST);
   wire wrap = cnt_step && (cnt_q == 8'hFF);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         acc_q <= '0;
         pre_q <= 3'h0;
         cnt_q <= 8'h00;
      end else if (clk_en_i) begin
         acc_q <= mclk_tick ? acc_sum - dsq_pkg::ACC_WRAP : acc_sum;
         if (mclk_tick) begin
            pre_q <= cnt_step ? 3'h0 : pre_q + 3'h1;
         end
         if (cnt_step) begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end

   // ****************************************
   // Converter phase sequencer
   // ****************************************
   dsq_pkg::dsq_phase_e phase_q, phase_d;
   logic [7:0] soft_q;
   logic [3:0] cfg_q;
   logic neg_seen_q;
   wire both = configure_pulse_i && phase_step_pulse_i;
   wire step_only = phase_step_pulse_i && !configure_pulse_i;
   wire line_pulse = polarity_done_line_i;
   wire in_sense_window = (phase_q == dsq_pkg::DSQ_INT_IN) && (soft_q >= dsq_pkg::SENSE_START);
   wire eoc = (phase_q == dsq_pkg::DSQ_INT_REF) && line_pulse;
   wire timed = (phase_q == dsq_pkg::DSQ_INT_IN) || (phase_q == dsq_pkg::DSQ_SIGN_SENSE)
      || (phase_q == dsq_pkg::DSQ_INT_REF);
   wire soft_wrap = soft_q == dsq_pkg::SOFT_LAST;

   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         dsq_pkg::DSQ_IDLE: phase_d = phase_q;
         dsq_pkg::DSQ_AUTO_ZERO: if (step_only) phase_d = dsq_pkg::DSQ_INT_IN;
         dsq_pkg::DSQ_INT_IN: if (step_only || (wrap && soft_wrap)) phase_d = dsq_pkg::DSQ_SIGN_SENSE;
         dsq_pkg::DSQ_SIGN_SENSE: if (step_only) phase_d = dsq_pkg::DSQ_INT_REF;
         dsq_pkg::DSQ_INT_REF: if (step_only || eoc) phase_d = dsq_pkg::DSQ_IDLE;
         default: phase_d = dsq_pkg::DSQ_IDLE;
      endcase
      if (both) begin
         phase_d = dsq_pkg::DSQ_AUTO_ZERO;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         phase_q <= dsq_pkg::DSQ_IDLE;
         soft_q <= 8'h00;
         cfg_q <= 4'h0;
         neg_seen_q <= 1'b0;
         az_reset_o <= 1'b0;
         conv_done_o <= 1'b0;
         result_latch_o <= 8'h00;
         soft_count_o <= 8'h00;
      end else if (clk_en_i) begin
         phase_q <= phase_d;
         az_reset_o <= both;
         conv_done_o <= eoc;
         if (both) begin
            soft_q <= 8'h00;
            cfg_q <= 4'h0;
            neg_seen_q <= 1'b0;
         end else if (configure_pulse_i && cfg_q != dsq_pkg::CFG_MAX) begin
            cfg_q <= cfg_q + 4'h1;
         end
         if (!both && wrap && timed) begin
            soft_q <= soft_wrap ? 8'h00 : soft_q + 8'h01;
         end
         if (in_sense_window && line_pulse) begin
            neg_seen_q <= 1'b1;
         end
         if (eoc) begin
            result_latch_o <= cnt_q;
            soft_count_o <= soft_q;
         end
      end
   end

   // ****************************************
   // Configuration decode
   // ****************************************
   wire [3:0] cfg_idx = (cfg_q > dsq_pkg::CFG_FINAL_LAST) ? dsq_pkg::CFG_FINAL_LAST : cfg_q;
   wire [3:0] cfg_m1 = cfg_idx - 4'h1;
   wire cfg_final = cfg_idx != 4'h0;
   wire [1:0] cfg_src = cfg_final ? cfg_m1[3:2] : 2'h0;
   wire [1:0] cfg_gain = cfg_final ? cfg_m1[1:0] : dsq_pkg::GAIN_X20;
   wire rj_zero = eoc && (cfg_src == dsq_pkg::SRC_RJ) && (cnt_q == 8'h00) && (soft_q == 8'h00);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cfg_count_o <= 4'h0;
         gain_sel_o <= dsq_pkg::GAIN_X20;
         input_sel_o <= 2'h0;
         final_conv_o <= 1'b0;
         self_check_o <= 1'b0;
         junction_corr_o <= 1'b0;
         phase_o <= 3'h0;
         polarity_flag_input_o <= 1'b0;
      end else if (clk_en_i) begin
         cfg_count_o <= cfg_q;
         input_sel_o <= cfg_src;
         final_conv_o <= cfg_final;
         gain_sel_o <= (cfg_src == dsq_pkg::SRC_RJ) ? dsq_pkg::GAIN_X20 : cfg_gain;
         phase_o <= phase_q;
         polarity_flag_input_o <= line_pulse || neg_seen_q;
         if (eoc && cfg_src == dsq_pkg::SRC_RJ) begin
            self_check_o <= rj_zero;
            junction_corr_o <= !rj_zero;
         end
      end
   end

   // ****************************************
   // Update cycle, scan and flash timing
   // ****************************************
   logic [9:0] upd_q;
   logic [9:0] flash_q;
   logic blank_q;
   logic [3:0] slot_q;
   wire [9:0] upd_last = final_window_o ? dsq_pkg::FINAL_WRAPS - 10'h1 : dsq_pkg::PRELIM_WRAPS - 10'h1;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         upd_q <= 10'h000;
         flash_q <= 10'h000;
         blank_q <= 1'b0;
         slot_q <= 4'h0;
         final_window_o <= 1'b0;
         update_tick_o <= 1'b0;
         irq_o <= 1'b0;
         counter_o <= 8'h00;
      end else if (clk_en_i) begin
         irq_o <= wrap;
         counter_o <= cnt_q;
         update_tick_o <= wrap && final_window_o && (upd_q == upd_last);
         if (wrap) begin
            upd_q <= (upd_q == upd_last) ? 10'h000 : upd_q + 10'h001;
            if (upd_q == upd_last) begin
               final_window_o <= !final_window_o;
            end
            slot_q <= (slot_q == dsq_pkg::SCAN_LAST) ? 4'h0 : slot_q + 4'h1;
            if (!low_battery_i) begin
               flash_q <= 10'h000;
               blank_q <= 1'b0;
            end else if (flash_q == dsq_pkg::FLASH_WRAPS - 10'h1) begin
               flash_q <= 10'h000;
               blank_q <= !blank_q;
            end else begin
               flash_q <= flash_q + 10'h001;
            end
         end
      end
   end

   // ****************************************
   // Display latches, flags and address
   // ****************************************
   logic [7:0] digit_q;
   logic [4:0] addr_hi_q;
   wire lit_slot = slot_q < dsq_pkg::DIGITS;
   wire [7:0] drive = (lit_slot && !blank_q) ? digit_q : 8'h00;
   wire [12:0] addr_full = {addr_hi_q, addr_lo_i};

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         digit_q <= 8'h00;
         addr_hi_q <= 5'h00;
         digit_select_latch_o <= 8'h00;
         segment_pattern_latch_o <= 8'h00;
         scan_slot_o <= 4'h0;
         low_battery_flag_input_o <= 1'b0;
         unit_switch_flag_input_o <= 1'b0;
         range_sense_flag_input_o <= 1'b0;
         mem_addr_o <= 13'h0000;
         rom_sel_o <= 1'b0;
         ram_sel_o <= 1'b0;
      end else if (clk_en_i) begin
         if (digit_wr_i) begin
            digit_q <= bus_data_i;
         end
         if (segment_wr_i) begin
            segment_pattern_latch_o <= bus_data_i;
         end
         digit_select_latch_o <= drive;
         scan_slot_o <= slot_q;
         low_battery_flag_input_o <= low_battery_i;
         unit_switch_flag_input_o <= unit_switch_i;
         range_sense_flag_input_o <= |(drive & range_position_i);
         if (addr_hi_wr_i) begin
            addr_hi_q <= bus_data_i[4:0];
         end
         mem_addr_o <= addr_full;
         rom_sel_o <= mem_req_i && (addr_full[12] == dsq_pkg::ROM_SPACE);
         ram_sel_o <= mem_req_i && (addr_full[12] != dsq_pkg::ROM_SPACE);
      end
   end
endmodule // dsq_ctrl
`default_nettype wire

/* File: dsq_front_end.sv */
/* Front end model: polarity pulse and end-of-conversion pulse on one line.
   Assumes phase_i is the sequencer phase output and fire_i comes from the bench. */
`timescale 1ns/1ps
`default_nettype none
module dsq_front_end (
   input wire logic clk_i,
   input wire logic clk_en_i,
   input wire logic [2:0] phase_i,
   input wire logic neg_i,
   input wire logic fire_i,
   output logic line_o
);
   logic [2:0] last_q = 3'h0;
   initial line_o = 1'h0;
   always @(negedge clk_i) begin
      last_q <= phase_i;
      line_o <= clk_en_i && ((phase_i == 3'h3 && last_q != 3'h3 && neg_i) || (phase_i == 3'h4 && fire_i));
   end
endmodule // dsq_front_end
`default_nettype wire

/* File: dsq_ctrl_asserts.sv */
/* Concurrent checks on the sequencer ports.
   Assumes one clock and the synchronous reset of dsq_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module dsq_ctrl_asserts (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic configure_pulse_i,
   input wire logic phase_step_pulse_i,
   input wire logic segment_wr_i,
   input wire logic [7:0] bus_data_i,
   input wire logic irq_o,
   input wire logic conv_done_o,
   input wire logic [2:0] phase_o,
   input wire logic az_reset_o,
   input wire logic [3:0] cfg_count_o,
   input wire logic [1:0] gain_sel_o,
   input wire logic [1:0] input_sel_o,
   input wire logic [7:0] digit_select_latch_o,
   input wire logic [7:0] segment_pattern_latch_o,
   input wire logic [3:0] scan_slot_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   az_start_a: assert property (configure_pulse_i && phase_step_pulse_i && clk_en_i
      |=> az_reset_o ##1 phase_o == 3'h1) else $error("auto-zero not started");
   irq_pulse_a: assert property (irq_o |=> !irq_o [*8]) else $error("interrupt held");
   dark_slot_a: assert property (scan_slot_o >= 4'h7 |-> digit_select_latch_o == 8'h00)
      else $error("dark slot lit");
   slot_range_a: assert property (scan_slot_o <= dsq_pkg::SCAN_LAST) else $error("bad scan slot");
   junction_gain_a: assert property (input_sel_o == dsq_pkg::SRC_RJ |-> gain_sel_o == dsq_pkg::GAIN_X20)
      else $error("junction gain wrong");
   cfg_limit_a: assert property (cfg_count_o <= dsq_pkg::CFG_MAX) else $error("too many setups");
   segment_load_a: assert property (segment_wr_i && clk_en_i |=> segment_pattern_latch_o == $past(bus_data_i))
      else $error("segment latch not loaded");
   done_idle_a: assert property (conv_done_o |-> ##[1:2] phase_o == 3'h0) else $error("no idle after done");
   cover property (az_reset_o);
   cover property (conv_done_o);
   cover property (irq_o ##1 !irq_o);
endmodule // dsq_ctrl_asserts
bind dsq_ctrl dsq_ctrl_asserts u_dsq_ctrl_asserts (
   .clk_i(clk_i),
   .reset_i(reset_i),
   .clk_en_i(clk_en_i),
   .configure_pulse_i(configure_pulse_i),
   .phase_step_pulse_i(phase_step_pulse_i),
   .segment_wr_i(segment_wr_i),
   .bus_data_i(bus_data_i),
   .irq_o(irq_o),
   .conv_done_o(conv_done_o),
   .phase_o(phase_o),
   .az_reset_o(az_reset_o),
   .cfg_count_o(cfg_count_o),
   .gain_sel_o(gain_sel_o),
   .input_sel_o(input_sel_o),
   .digit_select_latch_o(digit_select_latch_o),
   .segment_pattern_latch_o(segment_pattern_latch_o),
   .scan_slot_o(scan_slot_o)
);
`default_nettype wire

/* File: dsq_ctrl_tb.sv */
/* Self-checking bench for dsq_ctrl with a front end model.
   Assumes dsq_pkg, dsq_ctrl and dsq_front_end are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dsq_ctrl_tb;
   logic clk_i = 1'h0, reset_i = 1'h1, clk_en_i = 1'h1, configure_pulse_i = 1'h0, phase_step_pulse_i = 1'h0;
   logic low_battery_i = 1'h0, unit_switch_i = 1'h0, mem_req_i = 1'h0, digit_wr_i = 1'h0;
   logic segment_wr_i = 1'h0, addr_hi_wr_i = 1'h0, neg_q = 1'h0, fire_q = 1'h0, polarity_done_line_i;
   logic [7:0] range_position_i = 8'h01, bus_data_i = 8'h00, addr_lo_i = 8'h00;
   logic irq_o, conv_done_o, az_reset_o, final_conv_o, rom_sel_o, ram_sel_o, low_battery_flag_input_o;
   logic polarity_flag_input_o, unit_switch_flag_input_o, range_sense_flag_input_o, self_check_o, junction_corr_o;
   logic [7:0] counter_o, result_latch_o, soft_count_o, segment_pattern_latch_o, digit_select_latch_o;
   logic [3:0] cfg_count_o, scan_slot_o;
   logic [2:0] phase_o;
   logic [1:0] gain_sel_o, input_sel_o;
   logic [12:0] mem_addr_o;
   logic [31:0] r;
   int num_errors = 0, checks = 0, acc = 0, pre = 0, cnt = 0, cnt_d = 0, wraps = 0, irqs = 0, i, c, m, s, w, n, e;
   dsq_ctrl u_dsq_ctrl (.*, .final_window_o(), .update_tick_o());
   dsq_front_end u_dsq_front_end (.clk_i, .clk_en_i, .phase_i(phase_o), .neg_i(neg_q), .fire_i(fire_q),
      .line_o(polarity_done_line_i));
   initial forever #12.5 clk_i = ~clk_i;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test(input logic hung);
      if (hung) num_errors++;
      if (num_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic pulse(input logic cfg, input logic stp);
      @(negedge clk_i);
      configure_pulse_i = cfg;
      phase_step_pulse_i = stp;
      @(negedge clk_i);
      configure_pulse_i = 1'h0;
      phase_step_pulse_i = 1'h0;
   endtask
   // Timebase model: master tick, divide by six, 8-bit count
   always @(posedge clk_i) begin
      if (irq_o === 1'h1 && clk_en_i) irqs++;
      if (reset_i || clk_en_i) cnt_d = cnt;
      if (reset_i) begin
         acc = 0;
         pre = 0;
         cnt = 0;
      end else if (clk_en_i) begin
         acc += int'(dsq_pkg::MCLK_HZ);
         if (acc >= int'(dsq_pkg::CLK_HZ)) begin
            acc -= int'(dsq_pkg::CLK_HZ);
            pre = (pre + 1) % dsq_pkg::PRESCALE;
            if (pre == 0) cnt = (cnt + 1) % 256;
            if (pre == 0 && cnt == 0) wraps++;
         end
      end
   end
   always @(negedge clk_i) if (!reset_i) chk(counter_o, 16'(cnt_d));
   initial begin
      r = $urandom(84314);
      repeat (5) @(negedge clk_i);
      reset_i = 1'h0;
      chk(phase_o, 16'h0);
      for (c = 0; c < 15; c++) begin
         pulse(1'h1, 1'h1);
         repeat (c) pulse(1'h1, 1'h0);
         repeat (2) @(negedge clk_i);
         m = (c > 12) ? 12 : c;
         s = (m == 0) ? 0 : (m - 1) >> 2;
         chk(cfg_count_o, 16'((c > 13) ? 13 : c));
         chk(final_conv_o, 16'(m != 0));
         chk(input_sel_o, 16'(s));
         chk(gain_sel_o, 16'((m == 0 || s == 2) ? 0 : (m - 1) & 3));
      end
      repeat (4) begin
         r = $urandom;
         @(negedge clk_i);
         {low_battery_i, unit_switch_i, mem_req_i} = r[2:0];
         bus_data_i = r[15:8];
         addr_lo_i = r[23:16];
         range_position_i = 8'h01 << r[26:24];
         {digit_wr_i, segment_wr_i, addr_hi_wr_i} = 3'h7;
         @(negedge clk_i);
         {digit_wr_i, segment_wr_i, addr_hi_wr_i} = 3'h0;
         repeat (3) @(negedge clk_i);
         chk(low_battery_flag_input_o, 16'(r[2]));
         chk(unit_switch_flag_input_o, 16'(r[1]));
         chk(segment_pattern_latch_o, 16'(r[15:8]));
         chk(mem_addr_o, 16'({r[12:8], r[23:16]}));
         chk({ram_sel_o, rom_sel_o}, 16'(r[0] ? (r[12] ? 2 : 1) : 0));
         chk(scan_slot_o, 16'(wraps % 9));
         chk(digit_select_latch_o, 16'((wraps % 9 < 7) ? r[15:8] : 8'h00));
         chk(range_sense_flag_input_o, 16'((wraps % 9 < 7) && |(r[15:8] & (8'h01 << r[26:24]))));
      end
      for (n = 1; n >= 0; n--) begin
         neg_q = n[0];
         pulse(1'h1, 1'h1);
         repeat (9 * (1 - n)) pulse(1'h1, 1'h0);
         pulse(1'h0, 1'h1);
         repeat (2) @(negedge clk_i);
         chk(phase_o, 16'h2);
         w = wraps;
         for (i = 0; i < 30000 && wraps == w; i++) @(negedge clk_i);
         if (i >= 30000) finish_test(1'h1);
         pulse(1'h0, 1'h1);
         for (i = 0; i < 8 && polarity_flag_input_o !== 1'h1; i++) @(negedge clk_i);
         chk(polarity_flag_input_o, 16'(n));
         pulse(1'h0, 1'h1);
         repeat (2) @(negedge clk_i);
         chk(phase_o, 16'h4);
         for (i = 0; i < 120 && pre != 1; i++) @(negedge clk_i);
         if (i >= 120) finish_test(1'h1);
         fire_q <= 1'h1;
         @(negedge clk_i);
         e = cnt;
         fire_q <= 1'h0;
         for (i = 0; i < 8 && conv_done_o !== 1'h1; i++) @(negedge clk_i);
         if (i >= 8) finish_test(1'h1);
         chk(result_latch_o, 16'(e));
         chk(soft_count_o, 16'(wraps - w));
         chk(junction_corr_o, 16'(n == 0));
         chk(self_check_o, 16'h0);
         repeat (2) @(negedge clk_i);
         chk(phase_o, 16'h0);
      end
      // Zero junction reading right after a wrap
      pulse(1'h1, 1'h1);
      repeat (9) pulse(1'h1, 1'h0);
      w = wraps;
      for (i = 0; i < 30000 && wraps == w; i++) @(negedge clk_i);
      if (i >= 30000) finish_test(1'h1);
      repeat (3) pulse(1'h0, 1'h1);
      repeat (2) @(negedge clk_i);
      fire_q <= 1'h1;
      @(negedge clk_i);
      fire_q <= 1'h0;
      repeat (2) @(negedge clk_i);
      chk(result_latch_o, 16'h0);
      chk(self_check_o, 16'h1);
      chk(junction_corr_o, 16'h0);
      // Freeze with the enable low
      clk_en_i = 1'h0;
      repeat (20) @(negedge clk_i);
      clk_en_i = 1'h1;
      repeat (4) @(negedge clk_i);
      chk(16'(irqs), 16'(wraps));
      chk(scan_slot_o, 16'(wraps % 9));
      finish_test(1'h0);
   end
endmodule // dsq_ctrl_tb
`default_nettype wire
